// *** design/pps_defs.svh ***
// timing figures, tick counts and table contents of the power state sequencer
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_SYS_HZ        10000000
`define PPS_CK32K_HZ      32768
`define PPS_TICK_DIV      (`PPS_SYS_HZ / `PPS_CK32K_HZ)
`define PPS_T_BTN_MS      500
`define PPS_T_ADP_MS      100
`define PPS_T_BATT_MS     2
`define PPS_T_OFF2_MS     2
`define PPS_T_RST_MS      50
`define PPS_T_LP_INT_S    6
`define PPS_T_LP_OFF_S    8
`define PPS_MS2TK(ms)     (((ms) * `PPS_CK32K_HZ + 999) / 1000)
`define PPS_N_BTN         `PPS_MS2TK(`PPS_T_BTN_MS)
`define PPS_N_ADP         `PPS_MS2TK(`PPS_T_ADP_MS)
`define PPS_N_BATT        `PPS_MS2TK(`PPS_T_BATT_MS)
`define PPS_N_OFF2        `PPS_MS2TK(`PPS_T_OFF2_MS)
`define PPS_N_RST         `PPS_MS2TK(`PPS_T_RST_MS)
`define PPS_N_LP_INT      (`PPS_T_LP_INT_S * `PPS_CK32K_HZ)
`define PPS_N_LP_OFF      (`PPS_T_LP_OFF_S * `PPS_CK32K_HZ)
`define PPS_N_SLEEP_DB    3
`define PPS_N_STEP        66
`define PPS_N_STEP_LONG   132
`define PPS_N_SLP_ON      1
`define PPS_N_OFF1        1
`define PPS_LONG_STEP     4'h5
`define PPS_TBL_00        56'h01000033001254
`define PPS_TBL_01        56'h01000003201254
`define PPS_TBL_10        56'h05000022011344
`define PPS_TBL_11        56'h08050801067432
`define PPS_NCH           14
`endif

// *** design/pps_pkg.sv ***
// types of the power state sequencer
package pps_pkg;
    typedef enum logic [6:0] {
        PPS_OFF      = 7'h01,
        PPS_SEQ      = 7'h02,
        PPS_RST_WAIT = 7'h04,
        PPS_ON       = 7'h08,
        PPS_SLEEP    = 7'h10,
        PPS_SLP_WAKE = 7'h20,
        PPS_OFF_RST  = 7'h40
    } pps_state_t;
    typedef logic [1:0]  pps_boot_t;
    typedef logic [13:0] pps_chan_t;
endpackage

// *** design/pps_tick_gen.sv ***
// 32 kHz enable pulse divided from the system clock
`timescale 1ns/10ps
`include "pps_defs.svh"
module pps_tick_gen #(
    parameter int DIV = `PPS_TICK_DIV
) (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    output logic      tick_out
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } pps_tick_st_t;
    pps_tick_st_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 16'(DIV - 1)) begin
            s_next.cnt = 16'h0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_out = s_reg.tick;
endmodule

// *** design/pps_debounce.sv ***
// level debouncer counted in 32 kHz ticks, separate rise and fall times
`timescale 1ns/10ps
module pps_debounce #(
    parameter int   RISE_N = 1,
    parameter int   FALL_N = 1,
    parameter logic INIT   = 1'b0
) (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic tick_in,
    input  wire logic raw_in,
    output logic      level_out
);
    typedef struct packed {
        logic [17:0] cnt;
        logic        q;
    } pps_db_st_t;
    pps_db_st_t s_reg, s_next;
    logic [17:0] lim;

    always_comb begin
        s_next = s_reg;
        lim = raw_in ? 18'(RISE_N) : 18'(FALL_N);
        if (raw_in == s_reg.q) begin
            s_next.cnt = 18'h00000;
        end else if (tick_in) begin
            if (s_reg.cnt + 18'h00001 >= lim) begin
                s_next.q = raw_in;
                s_next.cnt = 18'h00000;
            end else begin
                s_next.cnt = s_reg.cnt + 18'h00001;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_reg <= '{cnt: 18'h00000, q: INIT};
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.q;
endmodule

// *** design/pps_sequencer.sv ***
// power state sequencer: on/off/sleep decisions and channel start-up order
// Operation
// - Turn on or stay on on button low, or on a fresh wake while off.
// - Button and plug-in edge wakes count only when their flag was clear; a debounced button low or an enabled alarm edge wakes with no flag.
// - While off, button low and first adapter plug-in raise wake flags.
// - Alarm wakes the off device only when its enable is set.
// - Long-press flag sets after the button stays low six seconds.
// - Button low eight seconds turns off and drops the host reset.
// - Thermal shutdown status forces the off state.
// - Debounced battery undervoltage lockout forces the off state.
// - Software off bits turn off; plain off bit is cleared once off.
// - Sleep on sleep input or software bit, only with no unmasked pending irq.
// - Sleep input edges are debounced three 32 kHz periods.
// - Channel enables return one 32 kHz period after the sleep exit edge.
// - Two strap inputs pick one of four start-up tables.
// - Strap 00 order: buck_four+load_switch_one, buck_three, linreg3+4, buck_one, buck_two.
// - First step 66 ticks after power-on enable, then 66 ticks per step.
// - In strap 11 the step after buck three waits 132 ticks.
// - Host reset released high 50 ms after the last channel.
// - Host reset falls one tick after the on condition is withdrawn.
// - All channels disabled 2 ms after host reset falls.
// - Button falling edge debounced 500 ms before a power-on request.
// - Adapter plug-in and plug-out debounced 100 ms each.
// - Battery-low both edges and undervolt falling edge debounced 2 ms.
// - Host reset is low whenever the device is off.
`timescale 1ns/10ps
`include "pps_defs.svh"
module pps_sequencer
    import pps_pkg::*;
#(
    parameter int TICK_DIV = `PPS_TICK_DIV,
    parameter int BTN_N    = `PPS_N_BTN,
    parameter int ADP_N    = `PPS_N_ADP,
    parameter int BATT_N   = `PPS_N_BATT,
    parameter int OFF2_N   = `PPS_N_OFF2,
    parameter int RST_N    = `PPS_N_RST,
    parameter int LP_INT_N = `PPS_N_LP_INT,
    parameter int LP_OFF_N = `PPS_N_LP_OFF
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        power_button_n_in,
    input  wire logic        adapter_detect_in,
    input  wire logic        battery_low_ind_in,
    input  wire logic        battery_undervolt_ind_in,
    input  wire logic        thermal_shutdown_status_in,
    input  wire logic        sleep_in,
    input  wire logic        sw_turn_off_in,
    input  wire logic        sw_turn_off_with_reset_in,
    input  wire logic        sw_sleep_request_in,
    input  wire logic        alarm_irq_in,
    input  wire logic        alarm_irq_en_in,
    input  wire logic        irq_pending_in,
    input  wire logic        button_low_irq_clr_in,
    input  wire logic        long_press_irq_clr_in,
    input  wire logic        plug_in_irq_clr_in,
    input  wire logic        strap_sel_lo_in,
    input  wire logic        strap_sel_hi_in,
    input  wire pps_chan_t   sleep_off_mask_in,
    output pps_chan_t        chan_en_out,
    output logic             host_reset_n_out,
    output logic             button_low_irq_flag_out,
    output logic             long_press_irq_flag_out,
    output logic             plug_in_irq_flag_out,
    output logic             battery_low_status_out,
    output logic             battery_uvlo_status_out,
    output logic             sleep_state_out,
    output logic             sw_turn_off_clear_out
);
    import pps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // start-up tables

    function automatic logic [3:0] step_of(input pps_boot_t b, input int ch);
        logic [55:0] t;
        case (b)
            2'h0:    t = `PPS_TBL_00;
            2'h1:    t = `PPS_TBL_01;
            2'h2:    t = `PPS_TBL_10;
            default: t = `PPS_TBL_11;
        endcase
        return t[ch*4 +: 4];
    endfunction

    function automatic pps_chan_t step_mask(input pps_boot_t b, input logic [3:0] st);
        pps_chan_t m;
        m = '0;
        for (int i = 0; i < `PPS_NCH; i++) begin
            m[i] = (st != 4'h0) ? (step_of(b, i) == st) : (step_of(b, i) != 4'h0);
        end
        return m;
    endfunction

    function automatic logic [3:0] last_step(input pps_boot_t b);
        logic [3:0] mx;
        mx = 4'h0;
        for (int i = 0; i < `PPS_NCH; i++) begin
            if (step_of(b, i) > mx) begin
                mx = step_of(b, i);
            end
        end
        return mx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // tick and input debouncing

    logic tick;
    logic btn_deb;
    logic adp_deb;
    logic blo_deb;
    logic buv_deb;
    logic slp_deb;

    pps_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .sys_clk_in(sys_clk_in),
        .reset_in  (reset_in),
        .tick_out  (tick)
    );

    pps_debounce #(.RISE_N(1), .FALL_N(BTN_N), .INIT(1'b1)) u_db_btn (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .tick_in(tick),
        .raw_in(power_button_n_in), .level_out(btn_deb)
    );
    pps_debounce #(.RISE_N(ADP_N), .FALL_N(ADP_N), .INIT(1'b0)) u_db_adp (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .tick_in(tick),
        .raw_in(adapter_detect_in), .level_out(adp_deb)
    );
    pps_debounce #(.RISE_N(BATT_N), .FALL_N(BATT_N), .INIT(1'b0)) u_db_blo (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .tick_in(tick),
        .raw_in(battery_low_ind_in), .level_out(blo_deb)
    );
    pps_debounce #(.RISE_N(1), .FALL_N(BATT_N), .INIT(1'b1)) u_db_buv (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .tick_in(tick),
        .raw_in(battery_undervolt_ind_in), .level_out(buv_deb)
    );
    pps_debounce #(.RISE_N(`PPS_N_SLEEP_DB), .FALL_N(`PPS_N_SLEEP_DB), .INIT(1'b0)) u_db_slp (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .tick_in(tick),
        .raw_in(sleep_in), .level_out(slp_deb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        pps_state_t  st;
        pps_boot_t   boot;
        logic [3:0]  step;
        logic [15:0] cnt;
        logic [18:0] lp_cnt;
        pps_chan_t   chan;
        logic        hrst_n;
        logic        btn_flag;
        logic        lp_flag;
        logic        plug_flag;
        logic        btn_q;
        logic        adp_q;
        logic        alarm_q;
        logic        sw_clr;
    } pps_st_t;
    pps_st_t s_reg, s_next;

    logic btn_set;
    logic plug_set;
    logic lp_set;
    logic lp_off;
    logic off_cond;
    logic wake_evt;
    logic slp_req;
    logic [15:0] step_dly;

    always_comb begin
        btn_set  = s_reg.btn_q & ~btn_deb;
        plug_set = ~s_reg.adp_q & adp_deb & ~s_reg.plug_flag;
        lp_set   = (s_reg.lp_cnt == 19'(LP_INT_N - 1)) & tick & ~power_button_n_in;
        lp_off   = s_reg.lp_cnt >= 19'(LP_OFF_N);
        off_cond = lp_off | thermal_shutdown_status_in | ~buv_deb
                 | sw_turn_off_in | sw_turn_off_with_reset_in;
        wake_evt = (btn_set & ~s_reg.btn_flag) | (plug_set & ~s_reg.plug_flag)
                 | (alarm_irq_in & ~s_reg.alarm_q & alarm_irq_en_in)
                 | ~btn_deb;
        slp_req  = (slp_deb | sw_sleep_request_in) & ~irq_pending_in;
        step_dly = ((s_reg.boot == 2'h3) && (s_reg.step + 4'h1 == `PPS_LONG_STEP))
                 ? 16'(`PPS_N_STEP_LONG) : 16'(`PPS_N_STEP);
    end

    always_comb begin
        s_next = s_reg;
        s_next.btn_q = btn_deb;
        s_next.adp_q = adp_deb;
        s_next.alarm_q = alarm_irq_in;
        s_next.sw_clr = (s_reg.st == PPS_OFF) & sw_turn_off_in;
        if (power_button_n_in && btn_deb) begin
            s_next.lp_cnt = 19'h00000;
        end else if (tick && !lp_off && !power_button_n_in) begin
            s_next.lp_cnt = s_reg.lp_cnt + 19'h00001;
        end
        if (button_low_irq_clr_in) begin
            s_next.btn_flag = 1'b0;
        end
        if (btn_set) begin
            s_next.btn_flag = 1'b1;
        end
        if (long_press_irq_clr_in) begin
            s_next.lp_flag = 1'b0;
        end
        if (lp_set) begin
            s_next.lp_flag = 1'b1;
        end
        if (plug_in_irq_clr_in) begin
            s_next.plug_flag = 1'b0;
        end
        if (plug_set) begin
            s_next.plug_flag = 1'b1;
        end
        case (s_reg.st)
            PPS_OFF: begin
                if (wake_evt && !off_cond) begin
                    s_next.st = PPS_SEQ;
                    s_next.boot = {strap_sel_hi_in, strap_sel_lo_in};
                    s_next.step = 4'h0;
                    s_next.cnt = 16'h0000;
                end
            end
            PPS_SEQ: begin
                if (off_cond) begin
                    s_next.st = PPS_OFF_RST;
                end else if (tick) begin
                    if (s_reg.cnt + 16'h0001 >= step_dly) begin
                        s_next.cnt = 16'h0000;
                        s_next.step = s_reg.step + 4'h1;
                        s_next.chan = s_reg.chan | step_mask(s_reg.boot, s_reg.step + 4'h1);
                        if (s_reg.step + 4'h1 == last_step(s_reg.boot)) begin
                            s_next.st = PPS_RST_WAIT;
                        end
                    end else begin
                        s_next.cnt = s_reg.cnt + 16'h0001;
                    end
                end
            end
            PPS_RST_WAIT: begin
                if (off_cond) begin
                    s_next.st = PPS_OFF_RST;
                end else if (tick) begin
                    if (s_reg.cnt + 16'h0001 >= 16'(RST_N)) begin
                        s_next.cnt = 16'h0000;
                        s_next.hrst_n = 1'b1;
                        s_next.st = PPS_ON;
                    end else begin
                        s_next.cnt = s_reg.cnt + 16'h0001;
                    end
                end
            end
            PPS_ON: begin
                if (off_cond) begin
                    s_next.st = PPS_OFF_RST;
                end else if (slp_req) begin
                    s_next.st = PPS_SLEEP;
                    s_next.chan = step_mask(s_reg.boot, 4'h0) & ~sleep_off_mask_in;
                end
            end
            PPS_SLEEP: begin
                if (off_cond) begin
                    s_next.st = PPS_OFF_RST;
                end else if (!slp_req) begin
                    s_next.st = PPS_SLP_WAKE;
                end
            end
            PPS_SLP_WAKE: begin
                if (off_cond) begin
                    s_next.st = PPS_OFF_RST;
                end else if (tick) begin
                    s_next.chan = step_mask(s_reg.boot, 4'h0);
                    s_next.st = PPS_ON;
                end
            end
            PPS_OFF_RST: begin
                if (tick && s_reg.hrst_n) begin
                    s_next.hrst_n = 1'b0;
                    s_next.cnt = 16'h0000;
                end else if (tick) begin
                    if (s_reg.cnt + 16'h0001 >= 16'(OFF2_N)) begin
                        s_next.chan = '0;
                        s_next.cnt = 16'h0000;
                        s_next.st = PPS_OFF;
                    end else begin
                        s_next.cnt = s_reg.cnt + 16'h0001;
                    end
                end
            end
            default: begin
                s_next.st = PPS_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_reg <= '{st: PPS_OFF, boot: 2'h0, step: 4'h0, cnt: 16'h0000,
                       lp_cnt: 19'h00000, chan: 14'h0000, hrst_n: 1'b0, btn_flag: 1'b0,
                       lp_flag: 1'b0, plug_flag: 1'b0, btn_q: 1'b1, adp_q: 1'b0,
                       alarm_q: 1'b0, sw_clr: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign chan_en_out             = s_reg.chan;
    assign host_reset_n_out        = s_reg.hrst_n;
    assign button_low_irq_flag_out = s_reg.btn_flag;
    assign long_press_irq_flag_out = s_reg.lp_flag;
    assign plug_in_irq_flag_out    = s_reg.plug_flag;
    assign battery_low_status_out  = blo_deb;
    assign battery_uvlo_status_out = ~buv_deb;
    assign sleep_state_out         = (s_reg.st == PPS_SLEEP);
    assign sw_turn_off_clear_out   = s_reg.sw_clr;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    off_reset_low_a: assert property (s_reg.st == PPS_OFF |-> !host_reset_n_out)
        else $error("host reset high while off");
    off_chan_zero_a: assert property ($rose(s_reg.st == PPS_OFF) |-> chan_en_out == '0)
        else $error("channels still on after power off");
    sw_clear_a: assert property (sw_turn_off_clear_out |-> $past(s_reg.st) == PPS_OFF)
        else $error("turn-off clear outside off state");
    long_press_a: assert property ($rose(s_reg.lp_flag) |-> $past(s_reg.lp_cnt) == 19'(LP_INT_N - 1))
        else $error("long press flag at wrong count");
    thermal_off_a: assert property (thermal_shutdown_status_in && s_reg.st == PPS_ON
                                    |=> s_reg.st == PPS_OFF_RST)
        else $error("thermal shutdown did not start power off");
    uvlo_off_a: assert property (!buv_deb && (s_reg.st == PPS_ON || s_reg.st == PPS_SLEEP)
                                 |=> s_reg.st == PPS_OFF_RST)
        else $error("undervoltage did not start power off");
    reset_fall_a: assert property ($fell(host_reset_n_out) |-> $past(s_reg.st) == PPS_OFF_RST
                                   && $past(tick))
        else $error("host reset fell outside power off");
    reset_rise_a: assert property ($rose(host_reset_n_out) |-> $past(s_reg.st) == PPS_RST_WAIT
                                   && $past(s_reg.cnt) == 16'(RST_N - 1))
        else $error("host reset released at wrong time");
    sleep_block_a: assert property (irq_pending_in && s_reg.st == PPS_ON |=> s_reg.st != PPS_SLEEP)
        else $error("sleep entered with pending interrupt");
    wake_start_a: assert property (s_reg.st == PPS_OFF && !wake_evt |=> s_reg.st == PPS_OFF)
        else $error("power up without wake event");
endmodule

// *** dv/pps_far_side.sv ***
// processor, power button and adapter-detect model on the far side of the sequencer
`timescale 1ns/10ps
module pps_far_side (
    input  wire logic sys_clk_in,
    input  wire logic host_reset_n_in,
    input  wire logic sleep_cmd_in,
    input  wire logic plug_cmd_in,
    output logic      power_button_n_out,
    output logic      adapter_detect_out,
    output logic      sleep_out
);
    initial power_button_n_out = 1'b1;
    // processor held in reset cannot ask for sleep
    assign sleep_out = sleep_cmd_in & host_reset_n_in;
    assign adapter_detect_out = plug_cmd_in;
    ////////////////////////////////////////////////////////////////////////////
    // contact bounce first, then a steady press of the given length
    task automatic press(input int cycles);
        repeat (2) begin
            power_button_n_out = 1'b0;
            @(posedge sys_clk_in);
            #1;
            power_button_n_out = 1'b1;
            @(posedge sys_clk_in);
            #1;
        end
        power_button_n_out = 1'b0;
        repeat (cycles) @(posedge sys_clk_in);
        #1;
        power_button_n_out = 1'b1;
    endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench of the power state sequencer
`timescale 1ns/10ps
`include "pps_defs.svh"
module tb;
    import pps_pkg::*;
    localparam int TDIV  = 4;
    localparam int LIMIT = 40000;
    localparam int NBTN  = 4;
    localparam int NADP  = 3;
    localparam int NBATT = 2;
    localparam int NOFF2 = 3;
    localparam int NRST  = 5;
    localparam int NLPI  = 20;
    localparam int NLPO  = 30;
    typedef struct {pps_chan_t chan; logic rst_n; int gap;} pps_note_t;
    logic        clk, rst, sleep_cmd, plug_cmd, alarm, alarm_en, pending, batt_low, sw_slp;
    logic        clr_btn, clr_lp, clr_plug, rst_n, btn_n, adp, slp, last_rst;
    logic        btn_flag, lp_flag, plug_flag, bl_stat, uv_stat, slp_stat, off_clr;
    logic [1:0]  strap;
    logic [3:0]  offc;
    pps_chan_t   mask, chan, last_chan, on;
    logic [55:0] tbl [4];
    pps_note_t   notes [$];
    int          bad_count, num_checks, gap_cnt, cycles;

    pps_far_side u_far (.sys_clk_in(clk), .host_reset_n_in(rst_n), .sleep_cmd_in(sleep_cmd),
        .plug_cmd_in(plug_cmd), .power_button_n_out(btn_n), .adapter_detect_out(adp),
        .sleep_out(slp));

    pps_sequencer #(.TICK_DIV(TDIV), .BTN_N(NBTN), .ADP_N(NADP), .BATT_N(NBATT),
        .OFF2_N(NOFF2), .RST_N(NRST), .LP_INT_N(NLPI), .LP_OFF_N(NLPO)) u_dut (
        .sys_clk_in(clk), .reset_in(rst), .power_button_n_in(btn_n), .adapter_detect_in(adp),
        .battery_low_ind_in(batt_low), .battery_undervolt_ind_in(~offc[3]),
        .thermal_shutdown_status_in(offc[2]), .sleep_in(slp), .sw_turn_off_in(offc[0]),
        .sw_turn_off_with_reset_in(offc[1]), .sw_sleep_request_in(sw_slp),
        .alarm_irq_in(alarm), .alarm_irq_en_in(alarm_en), .irq_pending_in(pending),
        .button_low_irq_clr_in(clr_btn), .long_press_irq_clr_in(clr_lp),
        .plug_in_irq_clr_in(clr_plug), .strap_sel_lo_in(strap[0]), .strap_sel_hi_in(strap[1]),
        .sleep_off_mask_in(mask), .chan_en_out(chan), .host_reset_n_out(rst_n),
        .button_low_irq_flag_out(btn_flag), .long_press_irq_flag_out(lp_flag),
        .plug_in_irq_flag_out(plug_flag), .battery_low_status_out(bl_stat),
        .battery_uvlo_status_out(uv_stat), .sleep_state_out(slp_stat),
        .sw_turn_off_clear_out(off_clr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic note(input pps_chan_t c, input logic r, input int g);
        notes.push_back(pps_note_t'{c, r, g});
    endtask

    // queue the start-up steps of one strap table, then the reset release
    task automatic expect_on(input int s);
        pps_chan_t bits;
        int        st;
        int        ch;
        on = '0;
        for (st = 1; st <= 8; st++) begin
            for (ch = 0; ch < 14; ch++) begin
                bits[ch] = (tbl[s][ch*4 +: 4] == 4'(st));
            end
            on = on | bits;
            if (bits != '0) begin
                note(on, 1'b0, st == 1 ? 0 : ((s == 3 && st == 5) ? 132 : 66) * TDIV);
            end
        end
        note(on, 1'b1, NRST * TDIV);
    endtask

    task automatic expect_off();
        note(on, 1'b0, 0);
        note('0, 1'b0, NOFF2 * TDIV);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (notes.size() != 0 && n < 4000) begin
            step(1);
            n++;
        end
        check(32'(notes.size()), 32'h0);
        step(2);
    endtask

    task automatic clear_flags();
        {clr_btn, clr_lp, clr_plug} = 3'h7;
        step(1);
        {clr_btn, clr_lp, clr_plug} = 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watcher: every change of enables or host reset takes the oldest note
    always @(posedge clk) begin
        pps_note_t n;
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            wrap_up();
        end
        gap_cnt++;
        if (rst) begin
            last_chan = chan;
            last_rst = rst_n;
            gap_cnt = 0;
        end else if (chan !== last_chan || rst_n !== last_rst) begin
            last_chan = chan;
            last_rst = rst_n;
            if (notes.size() == 0) begin
                check(32'({chan, rst_n}), 32'hFFFF_FFFF);
            end else begin
                n = notes.pop_front();
                check(32'({chan, rst_n}), 32'({n.chan, n.rst_n}));
                if (n.gap != 0) begin
                    check(32'(gap_cnt), 32'(n.gap));
                end
            end
            gap_cnt = 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, sleep_cmd, plug_cmd, alarm, alarm_en, pending, batt_low, sw_slp} = 8'h80;
        {clr_btn, clr_lp, clr_plug} = 3'h0;
        strap = 2'h0;
        offc = 4'h0;
        mask = '0;
        tbl = '{`PPS_TBL_00, `PPS_TBL_01, `PPS_TBL_10, `PPS_TBL_11};
        void'($urandom(32'h39971819));
        step(2);
        rst = 1'b0;
        check(32'({chan, rst_n, btn_flag, lp_flag, plug_flag, bl_stat, uv_stat}), 32'h0);
        batt_low = 1'b1;
        step(1 + $urandom_range(2));
        batt_low = 1'b0;
        step(4 * TDIV);
        check(32'(bl_stat), 32'h0);
        batt_low = 1'b1;
        step(4 * TDIV);
        check(32'(bl_stat), 32'h1);
        batt_low = 1'b0;
        step(4 * TDIV);
        check(32'(bl_stat), 32'h0);
        alarm = 1'b1;
        step(20 * TDIV);
        check(32'(chan), 32'h0);
        alarm = 1'b0;
        for (int i = 0; i < 4; i++) begin
            strap = 2'(i);
            mask = 14'($urandom) | 14'h0008;
            expect_on(i);
            if (i < 2) begin
                u_far.press(10 * TDIV);
            end else if (i == 2) begin
                plug_cmd = 1'b1;
            end else begin
                alarm_en = 1'b1;
                alarm = 1'b1;
            end
            drain();
            check(32'({btn_flag, plug_flag}), i < 2 ? 32'h2 : (i == 2 ? 32'h1 : 32'h0));
            alarm = 1'b0;
            if (i < 2) begin
                clear_flags();
                pending = 1'b1;
                sleep_cmd = 1'(i == 0);
                sw_slp = 1'(i == 1);
                step(10 * TDIV);
                check(32'(slp_stat), 32'h0);
                pending = 1'b0;
                note(on & ~mask, 1'b1, 0);
                drain();
                check(32'(slp_stat), 32'h1);
                sleep_cmd = 1'b0;
                sw_slp = 1'b0;
                note(on, 1'b1, 0);
                drain();
                check(32'(slp_stat), 32'h0);
            end
            expect_off();
            offc = 4'(1 << i);
            drain();
            check(32'({off_clr, uv_stat}), i == 0 ? 32'h2 : (i == 3 ? 32'h1 : 32'h0));
            u_far.press(10 * TDIV);
            step(20 * TDIV);
            check(32'(chan), 32'h0);
            offc = 4'h0;
            step(20 * TDIV);
            clear_flags();
            plug_cmd = 1'b0;
            step(5 * TDIV);
        end
        strap = 2'h0;
        expect_on(0);
        u_far.press(10 * TDIV);
        drain();
        clear_flags();
        expect_off();
        fork
            u_far.press(50 * TDIV);
        join_none
        step(18 * TDIV);
        check(32'(lp_flag), 32'h0);
        step(4 * TDIV);
        check(32'(lp_flag), 32'h1);
        drain();
        step(30 * TDIV);
        check(32'({chan, rst_n}), 32'h0);
        wrap_up();
    end
endmodule
